// [tb/pcdsr_chk.sv]
`timescale 1ns/1ps
module pcdsr_chk (
   // Strobes and modes
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic reg_wr,
   input wire logic debug_probe_mode,
   input wire logic pc_advance,
   input wire logic stack_top_wr,
   // Buses
   input wire logic [11:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   input wire logic [14:0] stack_entry,
   input wire logic [14:0] stack_top_wdata,
   input wire logic [14:0] program_counter,
   input wire logic [4:0] return_stack_pointer
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!arst_n);
   ////////////////////////////////////////////////////////////////////////
   // Counter checks
   property p_wl; reg_wr && reg_addr == 12'h002 |=> program_counter[7:0] == $past(reg_wdata); endproperty
   a_wl: assert property (p_wl) else $error("low write lost");
   property p_rl; reg_addr == 12'h002 |-> reg_rdata == program_counter[7:0]; endproperty
   a_rl: assert property (p_rl) else $error("low read bad");
   property p_inc; pc_advance && !(reg_wr && reg_addr == 12'h002) |=> program_counter == $past(program_counter) + 15'h1; endproperty
   a_inc: assert property (p_inc) else $error("advance bad");
   property p_rst; $rose(arst_n) |-> program_counter == 15'h0 && return_stack_pointer == 5'h1f; endproperty
   a_rst: assert property (p_rst) else $error("reset value bad");
   ////////////////////////////////////////////////////////////////////////
   // Debug bank checks; the user-mode gate hides the whole top bank
   property p_usr; !debug_probe_mode && reg_addr[11:7] == 5'h1f |-> reg_rdata == 8'h00; endproperty
   a_usr: assert property (p_usr) else $error("bank visible");
   property p_gap; reg_addr inside {[12'hf8c:12'hfe3], 12'hfec} |-> reg_rdata == 8'h00; endproperty
   a_gap: assert property (p_gap) else $error("hole not zero");
   property p_tw; reg_wr && debug_probe_mode && reg_addr == 12'hfee |-> stack_top_wr && stack_top_wdata[7:0] == reg_wdata; endproperty
   a_tw: assert property (p_tw) else $error("top write bad");
   property p_th; debug_probe_mode && reg_addr == 12'hfef |-> reg_rdata == {1'b0, stack_entry[14:8]}; endproperty
   a_th: assert property (p_th) else $error("top high bad");
   property p_sp; !(debug_probe_mode && reg_wr) |=> $stable(return_stack_pointer); endproperty
   a_sp: assert property (p_sp) else $error("pointer moved");
   property p_tu; !debug_probe_mode |-> !stack_top_wr; endproperty
   a_tu: assert property (p_tu) else $error("stack write outside debug");
   c_dbg: cover property ($rose(debug_probe_mode));
   c_inc: cover property (pc_advance);
   c_wl: cover property (reg_wr && reg_addr == 12'h002);
endmodule // pcdsr_chk
bind pcdsr_core_regs pcdsr_chk i_chk (
   .sys_clk(sys_clk),
   .arst_n(arst_n),
   .reg_wr(reg_wr),
   .debug_probe_mode(debug_probe_mode),
   .pc_advance(pc_advance),
   .stack_top_wr(stack_top_wr),
   .reg_addr(reg_addr),
   .reg_wdata(reg_wdata),
   .reg_rdata(reg_rdata),
   .stack_entry(stack_entry),
   .stack_top_wdata(stack_top_wdata),
   .program_counter(program_counter),
   .return_stack_pointer(return_stack_pointer)
);

// [tb/testbench.sv]
`timescale 1ns/1ps
module testbench;
   logic sys_clk = 0, arst_n = 0, por_bor_n = 0, reg_wr = 0, debug_probe_mode = 0, pc_advance = 0, stack_top_wr;
   logic [11:0] reg_addr = 12'h000;
   logic [7:0] reg_wdata = 8'h00, reg_rdata, core_working_reg = 8'ha7;
   logic [2:0] core_status_flags = 3'h5;
   logic [4:0] core_bank_select = 5'h13, return_stack_pointer;
   logic [15:0] core_ptr0 = 16'hc4e1, core_ptr1 = 16'h2b96;
   logic [14:0] stack_entry = 15'h5abc, stack_top_wdata, program_counter;
   localparam logic [7:0] SH [8] = '{8'h05, 8'ha7, 8'h13, 8'h72, 8'he1, 8'hc4, 8'h96, 8'h2b};
   int n_errors = 0, samples_checked = 0;
   pcdsr_core_regs i_dut (
      .sys_clk(sys_clk),
      .arst_n(arst_n),
      .por_bor_n(por_bor_n),
      .reg_addr(reg_addr),
      .reg_wr(reg_wr),
      .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata),
      .debug_probe_mode(debug_probe_mode),
      .pc_advance(pc_advance),
      .core_status_flags(core_status_flags),
      .core_working_reg(core_working_reg),
      .core_bank_select(core_bank_select),
      .core_ptr0(core_ptr0),
      .core_ptr1(core_ptr1),
      .stack_entry(stack_entry),
      .stack_top_wr(stack_top_wr),
      .stack_top_wdata(stack_top_wdata),
      .program_counter(program_counter),
      .return_stack_pointer(return_stack_pointer)
   );
   // Clock
   always #20 sys_clk = ~sys_clk;
   ////////////////////////////////////////////////////////////////////////
   // Shared tasks
   task automatic chk(input logic [14:0] got, input logic [14:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask
   // Stack top write leaves as a one-cycle strobe; look at it mid-cycle
   task automatic wr_top(input logic [11:0] a, input logic [7:0] d, input logic e_wr, input logic [14:0] e_data);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(negedge sys_clk);
      chk(stack_top_wr, e_wr);
      if (e_wr) chk(stack_top_wdata, e_data);
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask
   // Read data is combinational, so sample mid-cycle
   task automatic rd_is(input logic [11:0] a, input logic [7:0] e);
      @(posedge sys_clk);
      reg_addr <= a;
      @(negedge sys_clk);
      chk(reg_rdata, e);
   endtask
   ////////////////////////////////////////////////////////////////////////
   // Scenarios
   task automatic t_counter;
      wr(12'h00a, 8'hf2);
      @(negedge sys_clk);
      chk(program_counter, 15'h0);
      wr(12'h002, 8'hff);
      @(negedge sys_clk);
      chk(program_counter, 15'h72ff);
      @(posedge sys_clk);
      pc_advance <= 1'b1;
      @(posedge sys_clk);
      pc_advance <= 1'b0;
      @(negedge sys_clk);
      chk(program_counter, 15'h7300);
      rd_is(12'h002, 8'h00);
   endtask
   task automatic t_debug;
      wr(12'hfe5, 8'h3c);
      rd_is(12'hfe5, 8'h00);
      wr_top(12'hfee, 8'h99, 1'b0, 15'h0000);
      @(posedge sys_clk);
      debug_probe_mode <= 1'b1;
      stack_entry <= 15'h2d0f;
      for (int i = 0; i < 8; i++) rd_is(12'hfe4 + 12'(i), SH[i]);
      wr(12'hfe5, 8'h5a);
      rd_is(12'hfe5, 8'h5a);
      wr(12'hfec, 8'hff);
      rd_is(12'hfec, 8'h00);
      rd_is(12'hf8c, 8'h00);
      rd_is(12'hfee, 8'h0f);
      rd_is(12'hfef, 8'h2d);
      wr_top(12'hfee, 8'h99, 1'b1, 15'h2d99);
      wr_top(12'hfef, 8'hc1, 1'b1, 15'h410f);
      wr(12'hfed, 8'he3);
      rd_is(12'hfed, 8'h03);
   endtask
   task automatic t_reset;
      @(posedge sys_clk);
      arst_n <= 1'b0;
      @(posedge sys_clk);
      arst_n <= 1'b1;
      @(negedge sys_clk);
      chk(program_counter, 15'h0);
      chk(return_stack_pointer, 15'h1f);
      rd_is(12'hfe5, 8'h5a);
   endtask
   task automatic report_and_stop;
      $display("checks %0d errors %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // Main sequence
   initial begin
      repeat (3) @(posedge sys_clk);
      arst_n <= 1'b1;
      por_bor_n <= 1'b1;
      t_counter;
      t_debug;
      t_reset;
      report_and_stop;
   end
endmodule // testbench

// [verilog/pcdsr_core_regs.sv]
`timescale 1ns/1ps
// Program counter, stack access and debug shadow register slice
module pcdsr_core_regs (
   // Clock and resets
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic por_bor_n,
   // Register access from the core
   input wire logic [11:0] reg_addr,
   input wire logic reg_wr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   // Debug executive running
   input wire logic debug_probe_mode,
   // Program counter sequencing
   input wire logic pc_advance,
   // Core state copied into shadows on debug entry
   input wire logic [2:0] core_status_flags,
   input wire logic [7:0] core_working_reg,
   input wire logic [4:0] core_bank_select,
   input wire logic [15:0] core_ptr0,
   input wire logic [15:0] core_ptr1,
   // Stack top entry as seen by the stack memory
   input wire logic [pcdsr_pkg::PC_WIDTH-1:0] stack_entry,
   output logic stack_top_wr,
   output logic [pcdsr_pkg::PC_WIDTH-1:0] stack_top_wdata,
   // Program memory address
   output logic [pcdsr_pkg::PC_WIDTH-1:0] program_counter,
   output logic [pcdsr_pkg::SP_WIDTH-1:0] return_stack_pointer
);
   import pcdsr_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // Address map served here
   // 0x002        counter low byte, read/write from any mode
   // 0x00a        counter high latch, seven bits, read/write
   // 0xf80-0xfff  top bank, silent unless the debug executive runs
   // 0xfe4-0xfeb  shadow copies, one byte slot each, status first
   // 0xfed        return stack pointer, five bits
   // 0xfee/0xfef  top stack entry, low byte and seven-bit high byte
   // Shadow slot order: status, working, bank select, latch, pointer 0 low,
   // pointer 0 high, pointer 1 low, pointer 1 high.
   // Everything else in the top bank reads zero and drops writes.
   // Outside debug the whole top bank reads zero, which also hides
   // the stack registers from user code.
   // The low byte is decoded at one address only; bank mirrors of the
   // core registers belong to the bank logic outside this slice.

   ////////////////////////////////////////////////////////////////////////
   // Elaboration checks; they run once and cost no logic
   // Register slices below are fixed at seven high bits and a byte
   if (PC_WIDTH != 15) begin : g_bad_pc_width
      $error("program counter width must be fifteen bits");
   end
   // One spare pointer bit above the depth flags over/underflow
   if (SP_WIDTH != 5 || (1 << SP_WIDTH) < 2 * STACK_DEPTH) begin : g_bad_sp_width
      $error("stack pointer does not fit the stack depth");
   end
   // Pointer wrap only marks over/underflow cleanly for a power of two
   if (STACK_DEPTH < 2 || (STACK_DEPTH & (STACK_DEPTH - 1)) != 0) begin : g_bad_depth
      $error("stack depth must be a power of two");
   end

   ////////////////////////////////////////////////////////////////////////
   // State and decode nets, kept apart so read and write paths agree
   // Counter latch and debug entry tracking
   logic [6:0] counter_high_latch;
   logic debug_q;
   logic debug_entry;
   // Top bank decode and shadow access
   logic debug_hit;
   logic shadow_sel;
   logic [2:0] shadow_index;
   logic [7:0] shadow_rdata;
   logic [63:0] core_snapshot;
   // Per-register decode and write strobes
   logic hit_counter_low;
   logic hit_latch;
   logic hit_stack_pointer;
   logic hit_top_low;
   logic hit_top_high;
   logic write_counter_low;
   logic write_latch;
   logic write_stack_pointer;

   ////////////////////////////////////////////////////////////////////////
   // Access decode helpers
   // Whole top bank, shadows and stack registers alike
   function automatic logic in_debug_bank(input logic [11:0] a);
      return a >= ADDR_DEBUG_BANK_BASE;
   endfunction

   // Run of shadow slots, status shadow through pointer one high
   function automatic logic in_shadow_run(input logic [11:0] a);
      return a >= ADDR_STATUS_SHADOW && a <= ADDR_PTR1_HIGH_SHADOW;
   endfunction

   // Slot number from the address; wraps so the status shadow is slot zero
   function automatic logic [2:0] shadow_slot(input logic [11:0] a);
      return a[2:0] - ADDR_STATUS_SHADOW[2:0];
   endfunction

   // Debug bank only answers while the debug executive runs
   assign debug_hit = in_debug_bank(reg_addr) && debug_probe_mode;
   assign shadow_sel = debug_hit && in_shadow_run(reg_addr);
   assign shadow_index = shadow_slot(reg_addr);

   // User-side registers answer in either mode
   assign hit_counter_low = reg_addr == ADDR_COUNTER_LOW;
   assign hit_latch = reg_addr == ADDR_COUNTER_HIGH_LATCH;

   // Stack registers live in the top bank, so the debug gate applies
   assign hit_stack_pointer = debug_hit && reg_addr == ADDR_STACK_POINTER;
   assign hit_top_low = debug_hit && reg_addr == ADDR_STACK_TOP_LOW;
   assign hit_top_high = debug_hit && reg_addr == ADDR_STACK_TOP_HIGH;

   // One write strobe per register
   assign write_counter_low = reg_wr && hit_counter_low;
   assign write_latch = reg_wr && hit_latch;
   assign write_stack_pointer = reg_wr && hit_stack_pointer;

   ////////////////////////////////////////////////////////////////////////
   // Program counter
   // Only arst_n clears it; a low byte write beats the advance pulse so a
   // computed jump lands exactly where software asked.
   // Instruction fetch reads the whole counter; software sees the low byte.
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         program_counter <= PC_RESET;
      end else if (write_counter_low) begin
         // High bits come from the latch here; an advance can also carry into them
         program_counter <= {counter_high_latch, reg_wdata};
      end else if (pc_advance) begin
         // Wraps at the top of the fifteen-bit space
         program_counter <= program_counter + 15'h0001;
      end
   end

   // Counter high latch; bit 7 is not stored and reads back as zero
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         counter_high_latch <= LATCH_RESET;
      end else if (write_latch) begin
         counter_high_latch <= reg_wdata[6:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Stack access
   // Stack pointer, five bits to see over/underflow; the push/pop side
   // lives with the stack memory, this is only the register view
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         return_stack_pointer <= SP_RESET;
      end else if (write_stack_pointer) begin
         return_stack_pointer <= reg_wdata[4:0];
      end
   end

   // Stack top byte writes go out to the stack memory
   always_comb begin
      stack_top_wr = reg_wr && debug_hit &&
                     (reg_addr == ADDR_STACK_TOP_LOW || reg_addr == ADDR_STACK_TOP_HIGH);
      stack_top_wdata = (reg_addr == ADDR_STACK_TOP_LOW) ? {stack_entry[14:8], reg_wdata}
                                                        : {reg_wdata[6:0], stack_entry[7:0]};
   end

   ////////////////////////////////////////////////////////////////////////
   // Debug shadows
   // Entry edge detector. Only a power-on/brown-out clears it: a plain
   // reset while the debug executive keeps running must not look like a
   // fresh entry, or the capture would overwrite shadows that are meant
   // to survive that reset.
   always_ff @(posedge sys_clk or negedge por_bor_n) begin
      if (!por_bor_n) begin
         debug_q <= 1'b0;
      end else begin
         debug_q <= debug_probe_mode;
      end
   end

   // Capture happens once, on the first cycle of each debug session;
   // leaving debug needs no action, the shadows hold until the next entry
   assign debug_entry = debug_probe_mode && !debug_q;

   // Live core state packed slot by slot, status in the lowest byte;
   // unused high bits of each slot are zero so they read back as zero
   assign core_snapshot = {core_ptr1[15:8], core_ptr1[7:0], core_ptr0[15:8], core_ptr0[7:0],
                           1'b0, counter_high_latch, 3'h0, core_bank_select, core_working_reg,
                           5'h00, core_status_flags};

   // Shadow storage; the same slot number serves the write and read ports.
   // Capture beats a register write in the entry cycle; that write is
   // dropped, so the debug executive should not write on its first cycle.
   pcdsr_shadow_bank u_shadow (
      .sys_clk(sys_clk),
      .por_bor_n(por_bor_n),
      .wr_index(shadow_index),
      .wr_en(reg_wr && shadow_sel),
      .wr_data(reg_wdata),
      .capture(debug_entry),
      .core_values(core_snapshot),
      .rd_index(shadow_index),
      .rd_data(shadow_rdata)
   );

   ////////////////////////////////////////////////////////////////////////
   // Read mux; holes and unused bits answer zero
   // Combinational so a read completes in the cycle the address stands
   // Decodes are disjoint; the chain order is for readability only
   always_comb begin
      reg_rdata = 8'h00;
      if (hit_counter_low) begin
         reg_rdata = program_counter[7:0];
      end else if (hit_latch) begin
         reg_rdata = {1'b0, counter_high_latch};
      end else if (shadow_sel) begin
         reg_rdata = shadow_rdata;
      end else if (hit_stack_pointer) begin
         reg_rdata = {3'h0, return_stack_pointer};
      end else if (hit_top_low) begin
         reg_rdata = stack_entry[7:0];
      end else if (hit_top_high) begin
         reg_rdata = {1'b0, stack_entry[14:8]};
      end
   end
endmodule // pcdsr_core_regs

// [verilog/pcdsr_pkg.sv]
package pcdsr_pkg;
   ////////////////////////////////////////////////////////////////////////
   // Register addresses (12-bit data space)
   localparam logic [11:0] ADDR_COUNTER_LOW = 12'h002;
   localparam logic [11:0] ADDR_COUNTER_HIGH_LATCH = 12'h00a;
   localparam logic [11:0] ADDR_STATUS_SHADOW = 12'hfe4;
   localparam logic [11:0] ADDR_WORKING_SHADOW = 12'hfe5;
   localparam logic [11:0] ADDR_BANK_SHADOW = 12'hfe6;
   localparam logic [11:0] ADDR_LATCH_SHADOW = 12'hfe7;
   localparam logic [11:0] ADDR_PTR0_LOW_SHADOW = 12'hfe8;
   localparam logic [11:0] ADDR_PTR0_HIGH_SHADOW = 12'hfe9;
   localparam logic [11:0] ADDR_PTR1_LOW_SHADOW = 12'hfea;
   localparam logic [11:0] ADDR_PTR1_HIGH_SHADOW = 12'hfeb;
   localparam logic [11:0] ADDR_STACK_POINTER = 12'hfed;
   localparam logic [11:0] ADDR_STACK_TOP_LOW = 12'hfee;
   localparam logic [11:0] ADDR_STACK_TOP_HIGH = 12'hfef;
   localparam logic [11:0] ADDR_DEBUG_BANK_BASE = 12'hf80;
   ////////////////////////////////////////////////////////////////////////
   // Widths and reset values
   localparam int PC_WIDTH = 15;
   localparam int SP_WIDTH = 5;
   localparam int STACK_DEPTH = 16;
   localparam logic [14:0] PC_RESET = 15'h0000;
   localparam logic [6:0] LATCH_RESET = 7'h00;
   localparam logic [4:0] SP_RESET = 5'h1f;
   localparam logic [7:0] SHADOW_CLEAR = 8'h00;
endpackage

// [verilog/pcdsr_shadow_bank.sv]
`timescale 1ns/1ps
// Debug bank of normal-mode shadow copies
module pcdsr_shadow_bank (
   // Clock and power reset
   input wire logic sys_clk,
   input wire logic por_bor_n,
   // Register write port
   input wire logic [2:0] wr_index,
   input wire logic wr_en,
   input wire logic [7:0] wr_data,
   // Core capture on entry to debug
   input wire logic capture,
   input wire logic [63:0] core_values,
   // Read port
   input wire logic [2:0] rd_index,
   output logic [7:0] rd_data
);
   import pcdsr_pkg::*;
   // Valid bits per shadow: status, working, bank, latch, four pointers
   localparam logic [63:0] MASK = 64'hffffffff7f1fff07;
   logic [7:0] shadow [0:7];

   // Only power-on/brown-out clears; other resets leave contents alone
   always_ff @(posedge sys_clk or negedge por_bor_n) begin
      if (!por_bor_n) begin
         for (int i = 0; i < 8; i++) shadow[i] <= SHADOW_CLEAR;
      end else if (capture) begin
         for (int i = 0; i < 8; i++) shadow[i] <= core_values[i*8 +: 8] & MASK[i*8 +: 8];
      end else if (wr_en) begin
         shadow[wr_index] <= wr_data & MASK[wr_index*8 +: 8];
      end
   end

   assign rd_data = shadow[rd_index];
endmodule // pcdsr_shadow_bank
